// >>> rtl/tsil_pkg.sv
// tsil_pkg: offsets, field positions, reset values and timing counts
// for the transmit status and interrupt block.
// assumes a 12-bit byte-wide register port and a 100 MHz system clock.
package tsil_pkg;

	// ----------------
	// register offsets
	// ----------------
	localparam logic [11:0] OFS_TX_PORT_CTRL = 12'h18a; // test port control
	localparam logic [11:0] OFS_TEST_PORT_BIT_SUPPRESS = 12'h18b;
	localparam logic [11:0] OFS_TX_SYNCHRONIZER_CONTROL = 12'h18e;
	localparam logic [11:0] OFS_TX_LATCHED_STATUS_ONE = 12'h190;
	localparam logic [11:0] OFS_TX_LATCHED_STATUS_HDLC = 12'h191;
	localparam logic [11:0] OFS_TX_LATCHED_STATUS_SYNC = 12'h192;
	localparam logic [11:0] OFS_TX_INTERRUPT_SUMMARY = 12'h19f;
	localparam logic [11:0] OFS_TX_INTERRUPT_MASK_ONE = 12'h1a0;
	localparam logic [11:0] OFS_TX_INTERRUPT_MASK_HDLC = 12'h1a1;
	localparam logic [11:0] OFS_TX_INTERRUPT_MASK_SYNC = 12'h1a2;
	localparam logic [11:0] OFS_TX_FIFO_WATERMARK = 12'h187; // watermark select
	localparam logic [11:0] OFS_TX_MODE = 12'h1f0; // line mode and framing

	// ----------------
	// field positions
	// ----------------
	localparam int BIT_PORT_ENABLE = 0;
	localparam int BIT_CRC_SEARCH = 3;
	localparam int BIT_SYNC_ENABLE = 2;
	localparam int BIT_AUTO_INHIBIT = 1;
	localparam int BIT_RESYNC = 0;
	localparam int BIT_FULL = 7;
	localparam int BIT_EMPTY = 6;
	localparam int BIT_SLIP = 5;
	localparam int BIT_SLC = 4;
	localparam int BIT_DENS_ALIGN = 3;
	localparam int BIT_MFRAME = 2;
	localparam int BIT_CLK_RESTORED = 1;
	localparam int BIT_CLK_LOSS = 0;
	localparam int BIT_DL_EMPTY = 4;
	localparam int BIT_UNDERRUN = 3;
	localparam int BIT_MSG_END = 2;
	localparam int BIT_BELOW_WM = 1;
	localparam int BIT_NOT_FULL = 0;
	localparam int BIT_LOSS_LIVE = 1;
	localparam int BIT_LOSS_DETECT = 0;
	localparam int BIT_MODE_E1 = 0;
	localparam int BIT_MODE_ESF = 1;
	localparam int BIT_MODE_SLC = 2;

	// ----------------
	// reset values and widths
	// ----------------
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] MASK_HDLC_USED = 8'h1f;
	localparam logic [7:0] MASK_SYNC_USED = 8'h01;
	localparam logic [7:0] MASK_CTRL_USED = 8'h0f;
	localparam logic [6:0] FIFO_DEPTH = 7'h40; // 64-byte transmit fifo

	// watermark table, codes 00..11
	localparam logic [6:0] WM_CODE0 = 7'h04;
	localparam logic [6:0] WM_CODE1 = 7'h10;
	localparam logic [6:0] WM_CODE2 = 7'h20;
	localparam logic [6:0] WM_CODE3 = 7'h30;

	// ----------------
	// timing
	// ----------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOSS_LINE_PERIODS = 3; // line clock periods without edge
	localparam int LINE_PERIOD_NS = 648; // slowest line rate period, rounded up
	localparam int LOSS_TIME_NS = LOSS_LINE_PERIODS * LINE_PERIOD_NS;
	localparam int LOSS_CYCLES = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLC_FRAMES = 72; // frames per slc multiframe
	localparam int DATA_LINK_BITS = 8;

endpackage : tsil_pkg

// >>> rtl/tsil_top.sv
// tsil_top: per-port transmit status, mask and interrupt logic plus the
// test port and synchronizer control registers.
// assumes event pulses come from same-clock logic; the line clock is
// asynchronous and is synchronised before use.
//
// Functional notes
// - test port active only while enable set
// - suppress bits gate channel bits, msb first
// - crc multiframe search only in e1
// - synchronizer runs only while enabled
// - auto resync unless inhibit bit set
// - rising edge of resync starts one resync
// - every status bit except the live loss bit latches, can interrupt
// - full, empty, slip flags from elastic store
// - slc flag once per 72 frames
// - bit 3: density violation t1, align e1
// - multiframe flag on each multiframe boundary
// - clock restored flag when loss ends
// - clock loss after three idle periods
// - unmasked latched bit pulls interrupt low
// - data link empty after 8 bits, t1
// - underrun latches and forces abort
// - message end latches on completion
// - below watermark latches on rising edge
// - not full latches on rising edge
// - hunting holds live bit, latches detect
// - summary shows pending per group
// - mask bit one enables its status
// - watermark select 4, 16, 32, 48 bytes
module tsil_top #(
	parameter int LOSS_COUNT = tsil_pkg::LOSS_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// transmit line clock pin, asynchronous
	input wire logic transmit_line_clock,
	// event pulses from the transmit path
	input wire logic store_full_event,
	input wire logic store_empty_event,
	input wire logic frame_tick,
	input wire logic pulse_density_violation,
	input wire logic align_frame_event,
	input wire logic multiframe_event,
	input wire logic data_link_shift_done,
	input wire logic fifo_ran_empty,
	input wire logic message_end_flag,
	input wire logic [6:0] fifo_level,
	input wire logic sync_hunting,
	// control outputs
	output logic test_port_enable,
	output logic [7:0] channel_bit_suppress,
	output logic crc_multiframe_search,
	output logic synchronizer_enable,
	output logic auto_resync_allow,
	output logic resync_start,
	output logic abort_request,
	output logic frame_loss_live,
	output logic interrupt_out_n
);

	// ----------------
	// registers
	// ----------------
	logic [7:0] port_ctrl_q; // test port control
	logic [7:0] test_port_bit_suppress_q;
	logic [7:0] tx_synchronizer_control_q;
	logic [7:0] tx_latched_status_one_q;
	logic [7:0] tx_latched_status_hdlc_q;
	logic [7:0] tx_latched_status_sync_q;
	logic [7:0] tx_interrupt_mask_one_q;
	logic [7:0] tx_interrupt_mask_hdlc_q;
	logic [7:0] tx_interrupt_mask_sync_q;
	logic [1:0] watermark_select_q;
	logic [2:0] mode_q; // esf/slc/e1 selects
	logic resync_prev_q; // last resync bit
	logic resync_start_q;
	logic [7:0] reg_rdata_q;

	// line clock synchroniser and watchdog
	logic line_sync1_q; // first stage, read only by second
	logic line_sync2_q;
	logic line_prev_q;
	logic [15:0] idle_cnt_q;
	logic clock_loss_q; // live loss condition

	// edge memories for level conditions, and the slc frame counter
	logic below_wm_prev_q;
	logic not_full_prev_q;
	logic hunt_prev_q;
	logic [6:0] slc_cnt_q;

	// combinational helpers
	logic mode_e1;
	logic [6:0] wm_bytes;
	logic below_watermark_level;
	logic not_full_level;
	logic underrun;
	logic [7:0] set_one;
	logic [7:0] set_hdlc;
	logic [7:0] set_sync;
	logic line_edge;
	logic clock_back;
	logic slc_wrap;
	logic [2:0] summary;

	// write one clears; an event in the same cycle keeps the bit
	function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
			input logic hit, input logic [7:0] wd);
		logic [7:0] clr;
		clr = hit ? wd : 8'h00;
		return (cur & ~clr) | set;
	endfunction : w1c

	// ----------------
	// control register writes
	// ----------------

	// plain control registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			port_ctrl_q <= tsil_pkg::RST_REG;
			test_port_bit_suppress_q <= tsil_pkg::RST_REG;
			tx_synchronizer_control_q <= tsil_pkg::RST_REG;
			tx_interrupt_mask_one_q <= tsil_pkg::RST_REG;
			tx_interrupt_mask_hdlc_q <= tsil_pkg::RST_REG;
			tx_interrupt_mask_sync_q <= tsil_pkg::RST_REG;
			watermark_select_q <= 2'h0;
			mode_q <= 3'h0;
		end else if (reg_write) begin
			if (reg_addr == tsil_pkg::OFS_TX_PORT_CTRL) begin
				port_ctrl_q <= reg_wdata & 8'h01;
			end else if (reg_addr == tsil_pkg::OFS_TEST_PORT_BIT_SUPPRESS) begin
				test_port_bit_suppress_q <= reg_wdata;
			end else if (reg_addr == tsil_pkg::OFS_TX_SYNCHRONIZER_CONTROL) begin
				tx_synchronizer_control_q <= reg_wdata & tsil_pkg::MASK_CTRL_USED;
			end else if (reg_addr == tsil_pkg::OFS_TX_INTERRUPT_MASK_ONE) begin
				tx_interrupt_mask_one_q <= reg_wdata;
			end else if (reg_addr == tsil_pkg::OFS_TX_INTERRUPT_MASK_HDLC) begin
				tx_interrupt_mask_hdlc_q <= reg_wdata & tsil_pkg::MASK_HDLC_USED;
			end else if (reg_addr == tsil_pkg::OFS_TX_INTERRUPT_MASK_SYNC) begin
				tx_interrupt_mask_sync_q <= reg_wdata & tsil_pkg::MASK_SYNC_USED;
			end else if (reg_addr == tsil_pkg::OFS_TX_FIFO_WATERMARK) begin
				watermark_select_q <= reg_wdata[1:0];
			end else if (reg_addr == tsil_pkg::OFS_TX_MODE) begin
				mode_q <= reg_wdata[2:0];
			end
		end
	end

	// ----------------
	// control outputs
	// ----------------
	assign mode_e1 = mode_q[tsil_pkg::BIT_MODE_E1];
	assign test_port_enable = port_ctrl_q[tsil_pkg::BIT_PORT_ENABLE];
	// bit 7 is channel bit 8
	assign channel_bit_suppress = test_port_enable ? test_port_bit_suppress_q : 8'hff;
	assign crc_multiframe_search = mode_e1
		& tx_synchronizer_control_q[tsil_pkg::BIT_CRC_SEARCH];
	assign synchronizer_enable = tx_synchronizer_control_q[tsil_pkg::BIT_SYNC_ENABLE];
	assign auto_resync_allow = synchronizer_enable
		& ~tx_synchronizer_control_q[tsil_pkg::BIT_AUTO_INHIBIT];
	assign resync_start = resync_start_q;
	assign abort_request = underrun;
	assign frame_loss_live = synchronizer_enable & sync_hunting;

	// manual resync edge detector
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			resync_prev_q <= 1'b0;
			resync_start_q <= 1'b0;
		end else begin
			resync_prev_q <= tx_synchronizer_control_q[tsil_pkg::BIT_RESYNC];
			resync_start_q <= tx_synchronizer_control_q[tsil_pkg::BIT_RESYNC]
				& ~resync_prev_q & synchronizer_enable;
		end
	end

	// ----------------
	// line clock watchdog
	// ----------------

	// two-stage synchroniser, then edge compare on stage two
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			line_sync1_q <= 1'b0;
			line_sync2_q <= 1'b0;
			line_prev_q <= 1'b0;
		end else begin
			line_sync1_q <= transmit_line_clock;
			line_sync2_q <= line_sync1_q;
			line_prev_q <= line_sync2_q;
		end
	end
	assign line_edge = line_sync2_q ^ line_prev_q;

	// idle counter; loss set when it reaches the limit
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_cnt_q <= 16'h0000;
			clock_loss_q <= 1'b0;
		end else if (line_edge) begin
			idle_cnt_q <= 16'h0000;
			clock_loss_q <= 1'b0;
		end else if (idle_cnt_q >= 16'(LOSS_COUNT - 1)) begin
			clock_loss_q <= 1'b1;
		end else begin
			idle_cnt_q <= idle_cnt_q + 16'h0001;
		end
	end
	assign clock_back = clock_loss_q & line_edge;

	// ----------------
	// event conditioning
	// ----------------

	// slc frame counter, wraps every multiframe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			slc_cnt_q <= 7'h00;
		end else if (frame_tick) begin
			slc_cnt_q <= slc_wrap ? 7'h00 : slc_cnt_q + 7'h01;
		end
	end
	assign slc_wrap = frame_tick && (slc_cnt_q == 7'(tsil_pkg::SLC_FRAMES - 1));

	always_comb begin
		case (watermark_select_q)
			2'h0: wm_bytes = tsil_pkg::WM_CODE0;
			2'h1: wm_bytes = tsil_pkg::WM_CODE1;
			2'h2: wm_bytes = tsil_pkg::WM_CODE2;
			default: wm_bytes = tsil_pkg::WM_CODE3;
		endcase
	end
	assign below_watermark_level = fifo_level < wm_bytes;
	assign not_full_level = fifo_level < tsil_pkg::FIFO_DEPTH;
	assign underrun = fifo_ran_empty & ~message_end_flag;

	// previous levels for rising-edge detection
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			below_wm_prev_q <= 1'b1; // empty fifo is below: no edge at reset
			not_full_prev_q <= 1'b1;
			hunt_prev_q <= 1'b0;
		end else begin
			below_wm_prev_q <= below_watermark_level;
			not_full_prev_q <= not_full_level;
			hunt_prev_q <= frame_loss_live;
		end
	end

	// first group set vector
	always_comb begin
		set_one = 8'h00;
		set_one[tsil_pkg::BIT_FULL] = store_full_event;
		set_one[tsil_pkg::BIT_EMPTY] = store_empty_event;
		set_one[tsil_pkg::BIT_SLIP] = store_full_event | store_empty_event;
		// slc only in t1 with slc on
		set_one[tsil_pkg::BIT_SLC] = slc_wrap & ~mode_e1 & mode_q[tsil_pkg::BIT_MODE_SLC];
		set_one[tsil_pkg::BIT_DENS_ALIGN] = mode_e1 ? align_frame_event
			: pulse_density_violation;
		set_one[tsil_pkg::BIT_MFRAME] = multiframe_event;
		set_one[tsil_pkg::BIT_CLK_RESTORED] = clock_back;
		// loss latched on its onset; clearing while lost holds it low
		set_one[tsil_pkg::BIT_CLK_LOSS] = ~clock_loss_q & ~line_edge
			& (idle_cnt_q >= 16'(LOSS_COUNT - 1));
	end

	// hdlc group set vector
	always_comb begin
		set_hdlc = 8'h00;
		set_hdlc[tsil_pkg::BIT_DL_EMPTY] = data_link_shift_done & ~mode_e1;
		set_hdlc[tsil_pkg::BIT_UNDERRUN] = underrun;
		set_hdlc[tsil_pkg::BIT_MSG_END] = message_end_flag;
		set_hdlc[tsil_pkg::BIT_BELOW_WM] = below_watermark_level & ~below_wm_prev_q;
		set_hdlc[tsil_pkg::BIT_NOT_FULL] = not_full_level & ~not_full_prev_q;
	end

	// sync group set vector
	always_comb begin
		set_sync = 8'h00;
		set_sync[tsil_pkg::BIT_LOSS_DETECT] = frame_loss_live & ~hunt_prev_q;
	end

	// ----------------
	// latched status
	// ----------------

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_latched_status_one_q <= tsil_pkg::RST_REG;
			tx_latched_status_hdlc_q <= tsil_pkg::RST_REG;
			tx_latched_status_sync_q <= tsil_pkg::RST_REG;
		end else begin
			tx_latched_status_one_q <= w1c(tx_latched_status_one_q, set_one,
				reg_write && reg_addr == tsil_pkg::OFS_TX_LATCHED_STATUS_ONE, reg_wdata);
			tx_latched_status_hdlc_q <= w1c(tx_latched_status_hdlc_q, set_hdlc,
				reg_write && reg_addr == tsil_pkg::OFS_TX_LATCHED_STATUS_HDLC, reg_wdata);
			tx_latched_status_sync_q <= w1c(tx_latched_status_sync_q, set_sync,
				reg_write && reg_addr == tsil_pkg::OFS_TX_LATCHED_STATUS_SYNC, reg_wdata);
		end
	end

	// ----------------
	// interrupt
	// ----------------
	// per-group pending
	assign summary = {|(tx_latched_status_sync_q & tx_interrupt_mask_sync_q),
		|(tx_latched_status_hdlc_q & tx_interrupt_mask_hdlc_q),
		|(tx_latched_status_one_q & tx_interrupt_mask_one_q)};
	assign interrupt_out_n = ~(|summary);

	// ----------------
	// read port
	// ----------------

	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata_q <= tsil_pkg::RST_REG;
		end else if (!reg_read) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_addr == tsil_pkg::OFS_TX_PORT_CTRL) begin
			reg_rdata_q <= port_ctrl_q;
		end else if (reg_addr == tsil_pkg::OFS_TEST_PORT_BIT_SUPPRESS) begin
			reg_rdata_q <= test_port_bit_suppress_q;
		end else if (reg_addr == tsil_pkg::OFS_TX_SYNCHRONIZER_CONTROL) begin
			reg_rdata_q <= tx_synchronizer_control_q;
		end else if (reg_addr == tsil_pkg::OFS_TX_LATCHED_STATUS_ONE) begin
			reg_rdata_q <= tx_latched_status_one_q;
		end else if (reg_addr == tsil_pkg::OFS_TX_LATCHED_STATUS_HDLC) begin
			reg_rdata_q <= tx_latched_status_hdlc_q;
		end else if (reg_addr == tsil_pkg::OFS_TX_LATCHED_STATUS_SYNC) begin
			// live loss bit beside the latched detect bit
			reg_rdata_q <= {6'h00, frame_loss_live,
				tx_latched_status_sync_q[tsil_pkg::BIT_LOSS_DETECT]};
		end else if (reg_addr == tsil_pkg::OFS_TX_INTERRUPT_SUMMARY) begin
			reg_rdata_q <= {5'h00, summary};
		end else if (reg_addr == tsil_pkg::OFS_TX_INTERRUPT_MASK_ONE) begin
			reg_rdata_q <= tx_interrupt_mask_one_q;
		end else if (reg_addr == tsil_pkg::OFS_TX_INTERRUPT_MASK_HDLC) begin
			reg_rdata_q <= tx_interrupt_mask_hdlc_q;
		end else if (reg_addr == tsil_pkg::OFS_TX_INTERRUPT_MASK_SYNC) begin
			reg_rdata_q <= tx_interrupt_mask_sync_q;
		end else if (reg_addr == tsil_pkg::OFS_TX_FIFO_WATERMARK) begin
			reg_rdata_q <= {6'h00, watermark_select_q};
		end else if (reg_addr == tsil_pkg::OFS_TX_MODE) begin
			reg_rdata_q <= {5'h00, mode_q};
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end
	assign reg_rdata = reg_rdata_q;

endmodule : tsil_top

// >>> bench/tsil_chk.sv
// tsil_chk: port-level checks on the transmit status block.
// assumes it is bound to tsil_top and sees only its ports.
module tsil_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic test_port_enable,
	input wire logic [7:0] channel_bit_suppress,
	input wire logic synchronizer_enable,
	input wire logic auto_resync_allow,
	input wire logic resync_start,
	input wire logic fifo_ran_empty,
	input wire logic message_end_flag,
	input wire logic abort_request,
	input wire logic sync_hunting,
	input wire logic frame_loss_live,
	input wire logic interrupt_out_n
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------
	// assertions, one clock domain
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_abort_on_underrun: assert property (
		fifo_ran_empty && !message_end_flag |-> abort_request) else $error("abort missing");
	a_abort_only_underrun: assert property (
		abort_request |-> fifo_ran_empty && !message_end_flag) else $error("stray abort");
	a_loss_live_hunt: assert property (
		frame_loss_live == (sync_hunting && synchronizer_enable)) else $error("live loss wrong");
	a_resync_one_cycle: assert property (
		resync_start |=> !resync_start) else $error("resync pulse too long");
	a_resync_needs_enable: assert property (
		resync_start |-> synchronizer_enable) else $error("resync while disabled");
	a_auto_needs_enable: assert property (
		auto_resync_allow |-> synchronizer_enable) else $error("auto resync while disabled");
	a_suppress_when_off: assert property (
		!test_port_enable |-> channel_bit_suppress == 8'hff) else $error("port active when off");
	// a resync pulse must trace back to a control write two cycles earlier
	a_resync_from_write: assert property (
		$rose(resync_start) |-> $past(reg_write, 2) && $past(reg_wdata[0], 2)
		&& $past(reg_addr, 2) == tsil_pkg::OFS_TX_SYNCHRONIZER_CONTROL)
		else $error("resync without write");

	// main scenarios reached
	c_resync: cover property (resync_start);
	c_abort: cover property (abort_request);
	c_irq: cover property ($fell(interrupt_out_n));
	c_loss: cover property (frame_loss_live);

endmodule : tsil_chk

bind tsil_top tsil_chk i_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .test_port_enable(test_port_enable),
	.channel_bit_suppress(channel_bit_suppress), .synchronizer_enable(synchronizer_enable),
	.auto_resync_allow(auto_resync_allow), .resync_start(resync_start),
	.fifo_ran_empty(fifo_ran_empty), .message_end_flag(message_end_flag),
	.abort_request(abort_request), .sync_hunting(sync_hunting),
	.frame_loss_live(frame_loss_live), .interrupt_out_n(interrupt_out_n));

// >>> bench/tsil_host.sv
// tsil_host: host processor model on the register port.
// assumes read data stand one cycle after the read strobe.
module tsil_host (
	input wire logic clk,
	input wire logic reset,
	input wire logic interrupt_out_n,
	input wire logic [7:0] reg_rdata,
	input wire logic svc_en,
	output logic [11:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] last_summary
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sum, st; // service scratch

	initial begin
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		last_summary = 8'h00;
	end

	// one-cycle write strobe
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// interrupt service: summary first, then each pending group
	always begin
		@(posedge clk);
		if (svc_en === 1'b1 && interrupt_out_n === 1'b0 && reset === 1'b0) begin
			rd(tsil_pkg::OFS_TX_INTERRUPT_SUMMARY, sum);
			last_summary = sum;
			for (int g = 0; g < 3; g++) begin
				if (sum[g] === 1'b1) begin
					rd(tsil_pkg::OFS_TX_LATCHED_STATUS_ONE + 12'(g), st);
					wr(tsil_pkg::OFS_TX_LATCHED_STATUS_ONE + 12'(g), st);
				end
			end
		end
	end

endmodule : tsil_host

// >>> bench/tsil_top_tb_top.sv
// tsil_top_tb_top: self-checking bench for the transmit status block.
// assumes the host model owns the register port.
module tsil_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] A_ST1 = tsil_pkg::OFS_TX_LATCHED_STATUS_ONE,
		A_ST2 = tsil_pkg::OFS_TX_LATCHED_STATUS_HDLC,
		A_ST3 = tsil_pkg::OFS_TX_LATCHED_STATUS_SYNC,
		A_SUM = tsil_pkg::OFS_TX_INTERRUPT_SUMMARY,
		A_CTL = tsil_pkg::OFS_TX_SYNCHRONIZER_CONTROL,
		A_MD = tsil_pkg::OFS_TX_MODE,
		A_M1 = tsil_pkg::OFS_TX_INTERRUPT_MASK_ONE;
	logic clk, reset, reg_write, reg_read, lclk, lrun, hunt, svc;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, last_sum, outs, suppress;
	logic [8:0] ev; // event pulses, bit 8 is the frame tick
	logic [6:0] lvl;
	logic tp_en, crc, sync_en, auto_ok, resync_start, abort_req, loss_live, irq_n;
	int err_total, total_checks, nrs;

	// ----------------
	// clocks, design and host
	// ----------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// line clock edges never meet a rising system edge
	initial begin
		lclk = 1'b0;
		forever #14 if (lrun) lclk = ~lclk;
	end
	tsil_top #(.LOSS_COUNT(10)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .transmit_line_clock(lclk), .store_full_event(ev[0]),
		.store_empty_event(ev[1]), .frame_tick(ev[8]), .pulse_density_violation(ev[2]),
		.align_frame_event(ev[3]), .multiframe_event(ev[4]), .data_link_shift_done(ev[5]),
		.fifo_ran_empty(ev[6]), .message_end_flag(ev[7]), .fifo_level(lvl),
		.sync_hunting(hunt), .test_port_enable(tp_en), .channel_bit_suppress(suppress),
		.crc_multiframe_search(crc), .synchronizer_enable(sync_en),
		.auto_resync_allow(auto_ok), .resync_start(resync_start), .abort_request(abort_req),
		.frame_loss_live(loss_live), .interrupt_out_n(irq_n));
	tsil_host i_host (.clk(clk), .reset(reset), .interrupt_out_n(irq_n),
		.reg_rdata(reg_rdata), .svc_en(svc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .last_summary(last_sum));
	assign outs = {4'h0, tp_en, crc, sync_en, auto_ok};
	// count resync pulses, sampled mid-cycle where they are settled
	always @(negedge clk) if (resync_start === 1'b1) nrs++;

	// ----------------
	// helpers
	// ----------------
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		i_host.wr(a, d);
		#1;
	endtask : w
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		i_host.rd(a, v);
		chk($sformatf("reg %h", a), v, e);
	endtask : rc
	task automatic ci(input logic e);
		#1 chk("irq_n", {7'h00, irq_n}, {7'h00, e});
	endtask : ci
	task automatic pulse(input logic [8:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 9'h000;
		repeat (2) @(posedge clk);
	endtask : pulse
	task automatic lv(input logic [6:0] l);
		@(posedge clk);
		lvl <= l;
		repeat (3) @(posedge clk);
	endtask : lv

	// ----------------
	// scenarios
	// ----------------
	task automatic sc_reset();
		logic [11:0] a[9] = '{12'h18b, A_CTL, A_ST1, A_ST2, A_ST3, A_SUM, A_M1, 12'h1a1, 12'h1ff};
		ci(1'b1); // released after reset
		foreach (a[i]) rc(a[i], 8'h00); // reset values
		w(12'h1a1, 8'hff);
		rc(12'h1a1, tsil_pkg::MASK_HDLC_USED); // mask readback
		w(A_SUM, 8'hff);
		rc(A_SUM, 8'h00); // summary read only
	endtask : sc_reset
	task automatic sc_test_port();
		w(12'h18b, 8'hc1);
		chk("suppress", suppress, 8'hff); // port off
		w(tsil_pkg::OFS_TX_PORT_CTRL, 8'h01);
		chk("suppress", suppress, 8'hc1); // bit order kept
		chk("outs", outs, 8'h08); // port on
		w(tsil_pkg::OFS_TX_PORT_CTRL, 8'h00);
		chk("outs", outs, 8'h00); // port off again
	endtask : sc_test_port
	task automatic sc_sync_ctrl();
		logic [7:0] md[4] = '{8'h01, 8'h01, 8'h00, 8'h01};
		logic [7:0] cv[4] = '{8'h0c, 8'h0e, 8'h0c, 8'h08};
		logic [7:0] ex[4] = '{8'h07, 8'h06, 8'h03, 8'h04};
		for (int i = 0; i < 4; i++) begin
			w(A_MD, md[i]);
			w(A_CTL, cv[i]);
			chk("outs", outs, ex[i]); // control map
		end
		w(A_CTL, 8'h04);
		nrs = 0;
		w(A_CTL, 8'h05);
		w(A_CTL, 8'h05);
		repeat (4) @(posedge clk);
		chk("resyncs", 8'(nrs), 8'h01); // one per rise
		w(A_CTL, 8'h04);
		w(A_CTL, 8'h05);
		repeat (4) @(posedge clk);
		chk("resyncs", 8'(nrs), 8'h02); // cleared and set again
		w(A_CTL, 8'h00);
		w(A_CTL, 8'h01);
		repeat (4) @(posedge clk);
		chk("resyncs", 8'(nrs), 8'h02); // nothing while disabled
		w(A_MD, 8'h00);
	endtask : sc_sync_ctrl
	task automatic sc_status_one();
		logic [8:0] sel[6] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h008, 9'h010};
		logic [7:0] md[6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
		logic [7:0] ex[6] = '{8'ha0, 8'h60, 8'h08, 8'h08, 8'h00, 8'h04};
		w(A_M1, 8'hff);
		for (int i = 0; i < 6; i++) begin
			w(A_MD, md[i]);
			pulse(sel[i]);
			rc(A_ST1, ex[i]); // latched flags
			ci(ex[i] == 8'h00); // output follows status
			rc(A_SUM, {7'h00, ex[i] != 8'h00}); // group one pending
			w(A_ST1, 8'hff);
			rc(A_ST1, 8'h00); // ones clear
		end
		w(A_M1, 8'h80);
		pulse(9'h002);
		ci(1'b1); // masked stays quiet
		w(A_M1, 8'h40);
		ci(1'b0); // unmasking raises it
		fork
			w(A_ST1, 8'hff);
			pulse(9'h010);
		join
		rc(A_ST1, 8'h04); // new event beats clear
		w(A_ST1, 8'hff);
	endtask : sc_status_one
	task automatic sc_clock_loss();
		w(A_M1, 8'h03);
		lrun = 1'b0;
		repeat (40) @(posedge clk);
		rc(A_ST1, 8'h01); // loss flag
		ci(1'b0); // loss raises output
		w(A_ST1, 8'h01);
		rc(A_ST1, 8'h00); // cleared while loss persists
		ci(1'b1); // released
		lrun = 1'b1;
		repeat (20) @(posedge clk);
		rc(A_ST1, 8'h02); // restored flag
		w(A_ST1, 8'hff);
	endtask : sc_clock_loss
	task automatic sc_hdlc();
		logic [6:0] wm[4] = '{7'h04, 7'h10, 7'h20, 7'h30};
		w(12'h1a1, 8'h1f);
		for (int c = 0; c < 4; c++) begin
			w(tsil_pkg::OFS_TX_FIFO_WATERMARK, 8'(c));
			lv(7'h3f);
			lv(wm[c] - 7'h01);
			rc(A_ST2, 8'h02); // below chosen mark
			w(A_ST2, 8'hff);
		end
		lv(7'h40);
		lv(7'h3f);
		rc(A_ST2, 8'h01); // full to not full
		w(A_ST2, 8'hff);
		pulse(9'h040);
		rc(A_ST2, 8'h08); // underrun latched
		w(A_ST2, 8'hff);
		pulse(9'h0c0);
		rc(A_ST2, 8'h04); // end marked, no underrun
		rc(A_SUM, 8'h02); // group two pending
		w(A_ST2, 8'hff);
		pulse(9'h020);
		rc(A_ST2, 8'h10); // data link empty
		w(A_ST2, 8'hff);
	endtask : sc_hdlc
	task automatic sc_frame_loss();
		w(A_CTL, 8'h04);
		w(tsil_pkg::OFS_TX_INTERRUPT_MASK_SYNC, 8'h01);
		@(posedge clk);
		hunt <= 1'b1;
		repeat (3) @(posedge clk);
		rc(A_ST3, 8'h03); // live and latched
		rc(A_SUM, 8'h04); // group three pending
		ci(1'b0); // raised
		@(posedge clk);
		hunt <= 1'b0;
		w(A_ST3, 8'h01);
		rc(A_ST3, 8'h00); // live follows hunt
		ci(1'b1); // released
	endtask : sc_frame_loss
	task automatic sc_slc();
		w(A_MD, 8'h04);
		w(A_M1, 8'h10);
		repeat (71) pulse(9'h100);
		rc(A_ST1, 8'h00); // not before frame 72
		pulse(9'h100);
		rc(A_ST1, 8'h10); // set at frame 72
		w(A_ST1, 8'hff);
	endtask : sc_slc
	task automatic sc_service();
		w(A_M1, 8'hff);
		svc = 1'b1;
		pulse(9'h001);
		for (int k = 0; k < 40 && irq_n !== 1'b1; k++) @(posedge clk);
		ci(1'b1); // host service clears
		chk("summary", last_sum, 8'h01); // group one named
		svc = 1'b0;
	endtask : sc_service

	// ----------------
	// verdict and main sequence
	// ----------------
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	// a hang counts as a mismatch
	initial begin
		#900000;
		err_total++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		ev = 9'h000;
		lvl = 7'h28;
		hunt = 1'b0;
		svc = 1'b0;
		lrun = 1'b1;
		err_total = 0;
		total_checks = 0;
		nrs = 0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		sc_reset();
		sc_test_port();
		sc_sync_ctrl();
		sc_status_one();
		sc_clock_loss();
		sc_hdlc();
		sc_frame_loss();
		sc_slc();
		sc_service();
		conclude();
	end

endmodule : tsil_top_tb_top
